/* File: src/dfi_consts.svh */
// Purpose: Constants for the dual-function input channel
// Assumes: 100 MHz mclk, byte-wide register port
// Notes:   Offsets are byte addresses on the register port
//
// Overview of operation
// - Overvoltage compare, threshold lowered by hysteresis
// - Undervoltage compare, threshold raised by hysteresis
// - Function select chooses fault or warning roles
// - Select 11 blanks detector and input roles; over and under flags still follow
// - Invert bit 6 flips the sensed input
// - Bit 5 picks level or edge detection
// - Edges give pulses of 10 to 10000 us
// - Input glitch filter ignores short pulses
`ifndef DFI_CONSTS_SVH
`define DFI_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DFI_OFS_OV_TH 8'h30
`define DFI_OFS_OV_HYST 8'h31
`define DFI_OFS_UV_TH 8'h32
`define DFI_OFS_UV_HYST 8'h33
`define DFI_OFS_SFD_CFG 8'h34
`define DFI_OFS_FUNC_SEL 8'h35
`define DFI_OFS_GPI_CFG 8'h36

// ****************************************
// Writable bit masks and reset values
// ****************************************
`define DFI_MASK_HYST 8'h1f
`define DFI_MASK_SFD_CFG 8'h1f
`define DFI_MASK_FUNC_SEL 8'h03
`define DFI_MASK_GPI_CFG 8'h7f
`define DFI_RST_OV_TH 8'hff
`define DFI_RST_UV_TH 8'h00
`define DFI_RST_HYST 8'h00
`define DFI_RST_SFD_CFG 8'h03
`define DFI_RST_FUNC_SEL 8'h03
`define DFI_RST_GPI_CFG 8'h00

// ****************************************
// Field positions
// ****************************************
`define DFI_BIT_INVERT 6
`define DFI_BIT_DETECT 5

// ****************************************
// Timing
// ****************************************
`define DFI_CLK_PERIOD_NS 10
`define DFI_TICK_NS 1000
`define DFI_TICK_CYC (`DFI_TICK_NS / `DFI_CLK_PERIOD_NS)
`define DFI_GF_US_0 7'h00
`define DFI_GF_US_1 7'h05
`define DFI_GF_US_2 7'h0a
`define DFI_GF_US_3 7'h14
`define DFI_GF_US_4 7'h1e
`define DFI_GF_US_5 7'h32
`define DFI_GF_US_6 7'h4b
`define DFI_GF_US_7 7'h64
`define DFI_PULSE_US_0 14'h000a
`define DFI_PULSE_US_1 14'h0064
`define DFI_PULSE_US_2 14'h03e8
`define DFI_PULSE_US_3 14'h2710

`endif

/* File: src/dfi_pkg.sv */
// Purpose: Types and decode functions for the dual-function input
// Assumes: dfi_consts.svh supplies all figures
// Notes:   Struct layouts follow the register bit order
`include "dfi_consts.svh"
package dfi_pkg;

    // ****************************************
    // Register layouts
    // ****************************************
    typedef struct packed {
        logic [2:0] unused;
        logic [2:0] glitch_filter_select;
        logic [1:0] fault_type_select;
    } dfi_sfd_cfg_t;

    typedef struct packed {
        logic unused;
        logic input_invert;
        logic detect_type;
        logic [1:0] pulse_length_select;
        logic [2:0] glitch_filter_select;
    } dfi_gpi_cfg_t;

    // Flags handed to sequencing and fault logic
    typedef struct packed {
        logic over_flag;
        logic under_flag;
        logic sfd_fault;
        logic sfd_warning;
        logic gpi_fault;
    } dfi_flags_t;

    typedef enum logic {DFI_IDLE, DFI_PULSE} dfi_pulse_st_t;

    // Glitch code to microseconds, shared by both filters
    function automatic logic [6:0] dfi_gf_us(input logic [2:0] code);
        case (code)
            3'h0: dfi_gf_us = `DFI_GF_US_0;
            3'h1: dfi_gf_us = `DFI_GF_US_1;
            3'h2: dfi_gf_us = `DFI_GF_US_2;
            3'h3: dfi_gf_us = `DFI_GF_US_3;
            3'h4: dfi_gf_us = `DFI_GF_US_4;
            3'h5: dfi_gf_us = `DFI_GF_US_5;
            3'h6: dfi_gf_us = `DFI_GF_US_6;
            default: dfi_gf_us = `DFI_GF_US_7;
        endcase
    endfunction : dfi_gf_us

    // Pulse code to microseconds
    function automatic logic [13:0] dfi_pulse_us(input logic [1:0] code);
        case (code)
            2'h0: dfi_pulse_us = `DFI_PULSE_US_0;
            2'h1: dfi_pulse_us = `DFI_PULSE_US_1;
            2'h2: dfi_pulse_us = `DFI_PULSE_US_2;
            default: dfi_pulse_us = `DFI_PULSE_US_3;
        endcase
    endfunction : dfi_pulse_us

endpackage : dfi_pkg

/* File: src/dfi_glitch_filter.sv */
// Purpose: Glitch filter, output follows input once held long enough
// Assumes: tick is a one-cycle pulse each microsecond
// Notes:   Delay zero passes the input with one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module dfi_glitch_filter
    import dfi_pkg::*;
#(
    parameter int DW = 7
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic din,
    input wire logic [DW-1:0] delay_us,
    output logic dout
);

    logic [DW-1:0] cnt_r; // Microseconds the input has differed
    logic differs; // Input disagrees with the output
    logic done; // Hold time reached on this tick
    logic [DW-1:0] cnt_inc; // Next count

    assign differs = din != dout;
    assign cnt_inc = cnt_r + {{(DW-1){1'b0}}, 1'b1};
    assign done = (delay_us == '0) || (tick && cnt_inc >= delay_us);

    // ****************************************
    // Filter state
    // ****************************************
    // Any return to the old level restarts the count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dout <= 1'b0;
            cnt_r <= '0;
        end else if (!differs) begin
            cnt_r <= '0;
        end else if (done) begin
            dout <= din;
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_inc;
        end
    end

    // Output only moves on a tick unless the delay is zero
    filt_move_a: assert property (@(posedge mclk) disable iff (rst)
        !$stable(dout) |-> ($past(delay_us) == '0) || $past(tick))
        else $error("Filter output moved before hold time");

endmodule : dfi_glitch_filter
`default_nettype wire

/* File: src/dfi_input_channel.sv */
// Purpose: Dual-function monitored input: supply fault detector and logic input
// Assumes: level is the converted channel reading, pin is a synchronous logic level
// Notes:   Registers are written and read at their byte offsets on a simple port
`timescale 1ns/1ps
`default_nettype none
`include "dfi_consts.svh"
module dfi_input_channel
    import dfi_pkg::*;
#(
    parameter int TICK_CYC = `DFI_TICK_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] level,
    input wire logic pin,
    output dfi_flags_t flags
);

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] ov_th_r; // Overvoltage threshold
    logic [7:0] ov_hyst_r; // Overvoltage hysteresis, low five bits
    logic [7:0] uv_th_r; // Undervoltage threshold
    logic [7:0] uv_hyst_r; // Undervoltage hysteresis
    dfi_sfd_cfg_t sfd_cfg_r; // Detector glitch and fault type
    logic [7:0] func_sel_r; // Function select in low two bits
    dfi_gpi_cfg_t gpi_cfg_r; // Logic input settings
    logic [7:0] rdata_nxt; // Read mux

    // Write strobes per offset
    logic wr_ovt, wr_ovh, wr_uvt, wr_uvh, wr_sfd, wr_sel, wr_gpi;
    assign wr_ovt = reg_wr && reg_addr == `DFI_OFS_OV_TH;
    assign wr_ovh = reg_wr && reg_addr == `DFI_OFS_OV_HYST;
    assign wr_uvt = reg_wr && reg_addr == `DFI_OFS_UV_TH;
    assign wr_uvh = reg_wr && reg_addr == `DFI_OFS_UV_HYST;
    assign wr_sfd = reg_wr && reg_addr == `DFI_OFS_SFD_CFG;
    assign wr_sel = reg_wr && reg_addr == `DFI_OFS_FUNC_SEL;
    assign wr_gpi = reg_wr && reg_addr == `DFI_OFS_GPI_CFG;

    // Unused bits are masked on write so they read as zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ov_th_r <= `DFI_RST_OV_TH;
            ov_hyst_r <= `DFI_RST_HYST;
            uv_th_r <= `DFI_RST_UV_TH;
            uv_hyst_r <= `DFI_RST_HYST;
            sfd_cfg_r <= `DFI_RST_SFD_CFG;
            func_sel_r <= `DFI_RST_FUNC_SEL;
            gpi_cfg_r <= `DFI_RST_GPI_CFG;
        end else begin
            if (wr_ovt) ov_th_r <= reg_wdata;
            if (wr_ovh) ov_hyst_r <= reg_wdata & `DFI_MASK_HYST;
            if (wr_uvt) uv_th_r <= reg_wdata;
            if (wr_uvh) uv_hyst_r <= reg_wdata & `DFI_MASK_HYST;
            if (wr_sfd) sfd_cfg_r <= reg_wdata & `DFI_MASK_SFD_CFG;
            if (wr_sel) func_sel_r <= reg_wdata & `DFI_MASK_FUNC_SEL;
            if (wr_gpi) gpi_cfg_r <= reg_wdata & `DFI_MASK_GPI_CFG;
        end
    end

    // Read mux, unmapped offsets read as zero
    assign rdata_nxt = (reg_addr == `DFI_OFS_OV_TH) ? ov_th_r :
                       (reg_addr == `DFI_OFS_OV_HYST) ? ov_hyst_r :
                       (reg_addr == `DFI_OFS_UV_TH) ? uv_th_r :
                       (reg_addr == `DFI_OFS_UV_HYST) ? uv_hyst_r :
                       (reg_addr == `DFI_OFS_SFD_CFG) ? sfd_cfg_r :
                       (reg_addr == `DFI_OFS_FUNC_SEL) ? func_sel_r :
                       (reg_addr == `DFI_OFS_GPI_CFG) ? gpi_cfg_r : 8'h00;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) reg_rdata <= 8'h00;
        else reg_rdata <= rdata_nxt;
    end

    // ****************************************
    // Microsecond tick
    // ****************************************
    logic [15:0] div_r; // Divider count
    logic tick_r; // One-cycle pulse each microsecond
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (div_r == 16'(TICK_CYC - 1)) begin
            div_r <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // ****************************************
    // Supply fault detector
    // ****************************************
    logic ov_r, uv_r; // Comparator states with hysteresis
    logic [7:0] ov_eff, uv_eff; // Effective thresholds
    logic [8:0] uv_sum; // Wide sum to catch overflow
    logic ov_en, uv_en; // Fault type decode
    logic sfd_raw; // Enabled compare result
    logic sfd_filt; // After glitch delay

    // Saturate so hysteresis never wraps the threshold
    assign ov_eff = !ov_r ? ov_th_r :
        (ov_th_r > ov_hyst_r) ? (ov_th_r - ov_hyst_r) : 8'h00;
    assign uv_sum = {1'b0, uv_th_r} + {1'b0, uv_hyst_r};
    assign uv_eff = !uv_r ? uv_th_r : (uv_sum[8] ? 8'hff : uv_sum[7:0]);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ov_r <= 1'b0;
            uv_r <= 1'b0;
        end else begin
            ov_r <= level > ov_eff;
            uv_r <= level < uv_eff;
        end
    end

    // Type 00 over only, 01 both, 10 under only, 11 off
    assign ov_en = sfd_cfg_r.fault_type_select[1] == 1'b0;
    assign uv_en = sfd_cfg_r.fault_type_select == 2'h1 ||
                   sfd_cfg_r.fault_type_select == 2'h2;
    assign sfd_raw = (ov_r && ov_en) || (uv_r && uv_en);

    dfi_glitch_filter #(.DW(7)) u_sfd_filt (
        .mclk(mclk),
        .rst(rst),
        .tick(tick_r),
        .din(sfd_raw),
        .delay_us(dfi_gf_us(sfd_cfg_r.glitch_filter_select)),
        .dout(sfd_filt)
    );

    // ****************************************
    // Logic input
    // ****************************************
    logic gpi_in; // Pin after optional inversion
    logic gpi_filt; // After glitch filter
    logic gpi_prev_r; // Last filtered level, for edges
    logic gpi_edge; // Either edge seen
    dfi_pulse_st_t st_r; // Pulse stretcher state
    logic [13:0] pcnt_r; // Microseconds into pulse
    logic [13:0] pulse_len; // Selected length
    logic gpi_val; // Level or stretched pulse

    assign gpi_in = pin ^ gpi_cfg_r.input_invert;

    dfi_glitch_filter #(.DW(7)) u_gpi_filt (
        .mclk(mclk),
        .rst(rst),
        .tick(tick_r),
        .din(gpi_in),
        .delay_us(dfi_gf_us(gpi_cfg_r.glitch_filter_select)),
        .dout(gpi_filt)
    );

    assign gpi_edge = gpi_filt != gpi_prev_r;
    assign pulse_len = dfi_pulse_us(gpi_cfg_r.pulse_length_select);

    // Stretcher; a new edge mid-pulse restarts the length
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= DFI_IDLE;
            pcnt_r <= 14'h0000;
            gpi_prev_r <= 1'b0;
        end else begin
            gpi_prev_r <= gpi_filt;
            case (st_r)
                DFI_IDLE: begin
                    if (gpi_edge && gpi_cfg_r.detect_type) begin
                        st_r <= DFI_PULSE;
                        pcnt_r <= 14'h0000;
                    end
                end
                DFI_PULSE: begin
                    if (gpi_edge) begin
                        pcnt_r <= 14'h0000;
                    end else if (tick_r) begin
                        if (pcnt_r + 14'h0001 >= pulse_len) st_r <= DFI_IDLE;
                        pcnt_r <= pcnt_r + 14'h0001;
                    end
                end
                default: st_r <= DFI_IDLE;
            endcase
        end
    end

    assign gpi_val = gpi_cfg_r.detect_type ? (st_r == DFI_PULSE) : gpi_filt;

    // ****************************************
    // Role selection and outputs
    // ****************************************
    logic [1:0] fsel; // Function select field
    dfi_flags_t flags_nxt; // Next output flags
    assign fsel = func_sel_r[1:0];
    // Select 11 leaves the level reading only for over_flag and under_flag
    assign flags_nxt.over_flag = ov_r;
    assign flags_nxt.under_flag = uv_r;
    assign flags_nxt.sfd_fault = fsel == 2'h0 && sfd_filt;
    assign flags_nxt.sfd_warning = fsel == 2'h2 && sfd_filt;
    assign flags_nxt.gpi_fault = (fsel == 2'h1 || fsel == 2'h2) && gpi_val;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) flags <= '0;
        else flags <= flags_nxt;
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence ov_low_s;
        !ov_r && level > ov_th_r;
    endsequence
    sequence lvl_mode_s;
        fsel == 2'h1 && !gpi_cfg_r.detect_type && gpi_cfg_r.glitch_filter_select == 3'h0;
    endsequence

    ov_set_a: assert property (@(posedge mclk) disable iff (rst)
        ov_low_s |=> ov_r)
        else $error("Overvoltage not raised above threshold");
    ov_hold_a: assert property (@(posedge mclk) disable iff (rst)
        ov_r && ov_th_r > ov_hyst_r && level > ov_th_r - ov_hyst_r |=> ov_r)
        else $error("Overvoltage dropped inside hysteresis");
    uv_set_a: assert property (@(posedge mclk) disable iff (rst)
        !uv_r && level < uv_th_r |=> uv_r)
        else $error("Undervoltage not raised below threshold");
    sel_off_a: assert property (@(posedge mclk) disable iff (rst)
        fsel == 2'h3 |=> !flags.sfd_fault && !flags.sfd_warning && !flags.gpi_fault)
        else $error("Flag raised with functions off");
    sel_sfd_a: assert property (@(posedge mclk) disable iff (rst)
        fsel == 2'h0 |=> !flags.gpi_fault && !flags.sfd_warning && flags.sfd_fault == $past(sfd_filt))
        else $error("Detector-only role wrong");
    type_off_a: assert property (@(posedge mclk) disable iff (rst)
        sfd_cfg_r.fault_type_select == 2'h3 |-> !sfd_raw)
        else $error("Detector active with type off");
    inv_level_a: assert property (@(posedge mclk) disable iff (rst)
        lvl_mode_s [*3] |-> flags.gpi_fault == ($past(pin, 2) ^ $past(gpi_cfg_r.input_invert, 2)))
        else $error("Level input not passed with inversion");
    edge_start_a: assert property (@(posedge mclk) disable iff (rst)
        gpi_edge && gpi_cfg_r.detect_type |=> st_r == DFI_PULSE)
        else $error("Edge did not start a pulse");
    pulse_len_a: assert property (@(posedge mclk) disable iff (rst)
        st_r == DFI_PULSE && !gpi_edge |-> pcnt_r < pulse_len)
        else $error("Pulse outlived its length");

endmodule : dfi_input_channel
`default_nettype wire

/* File: test/dfi_rail_model.sv */
// Purpose: Stand-in for the monitored rail and the external logic signal
// Assumes: Caller acts 1 ns after a rising mclk edge
// Notes:   Both outputs are driven levels, never released
`timescale 1ns/1ps
`default_nettype none
module dfi_rail_model (
    input wire logic mclk,
    output logic [7:0] level,
    output logic pin
);
    // ****************
    // Far-side state
    // ****************
    logic [7:0] level_v; // Present converted reading
    logic pin_v; // Present logic signal level

    // Pins always show the present far-side state
    assign level = level_v;
    assign pin = pin_v;

    // Mid-rail reading and a low pin, so no fault at start
    initial begin
        level_v = 8'h60;
        pin_v = 1'b0;
    end

    // Move the rail to a new converted reading
    task set_level(input logic [7:0] v);
        level_v = v;
    endtask : set_level

    // Drive the logic signal to a level
    task set_pin(input logic v);
        pin_v = v;
    endtask : set_pin

    // Brief excursion of n edges, as a glitch would be
    task pulse_pin(input int n);
        pin_v = ~pin_v;
        repeat (n) @(posedge mclk);
        #1 pin_v = ~pin_v;
    endtask : pulse_pin
endmodule : dfi_rail_model
`default_nettype wire

/* File: test/tb_dual_function_input_config.sv */
// Purpose: Self-checking bench for the dual-function input channel
// Assumes: Tick shortened to 2 cycles, so all us figures are ticks
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
module tb_dual_function_input_config;
    import dfi_pkg::*;
    // ****************
    // Setup
    // ****************
    localparam int TC = 2; // Cycles per tick, short to keep run brief
    localparam int LIMIT = 60000; // Longest pulse is 20000 cycles
    logic mclk, rst, reg_wr, pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, level;
    dfi_flags_t flags;
    int error_cnt, comparisons, cyc, n;
    int gf[8] = '{0, 5, 10, 20, 30, 50, 75, 100}; // Filter holds in ticks
    int plen[4] = '{10, 100, 1000, 10000}; // Pulse lengths in ticks
    logic [7:0] rst_v[8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00};
    logic [7:0] msk_v[8] = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'h1f, 8'h03, 8'h7f, 8'h00};

    dfi_input_channel #(.TICK_CYC(TC)) dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .level(level), .pin(pin), .flags(flags));
    dfi_rail_model rail (.mclk(mclk), .level(level), .pin(pin));

    // Free-running 100 MHz clock
    always #5 mclk = ~mclk;

    // Hang guard counts as a failure
    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            report_and_stop();
        end
    end

    // ****************
    // Tasks
    // ****************
    // Verdict and end of run
    task report_and_stop;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // One clock, landing just after the edge
    task step;
        @(posedge mclk);
        #1;
    endtask : step

    // One-cycle write strobe, then an idle cycle so strobes never abut
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step();
        reg_wr = 1'b0;
        step();
    endtask : wr

    // Read data is registered, so look one edge later
    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        step();
        `CHK(reg_rdata, e, "read")
    endtask : rd

    // Bounded wait for a flag bit; n gives cycles taken
    task wait_flag(input int b, input logic v, input int hi);
        n = 0;
        while (flags[b] !== v && n <= hi) begin
            step();
            n++;
        end
    endtask : wait_flag

    // ****************
    // Sequence
    // ****************
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        error_cnt = 0;
        comparisons = 0;
        cyc = 0;
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        // Reset values, masks, and an unmapped offset
        for (int i = 0; i < 8; i++) rd(8'h30 + i[7:0], rst_v[i]);
        for (int i = 0; i < 8; i++) wr(8'h30 + i[7:0], 8'hff);
        for (int i = 0; i < 8; i++) rd(8'h30 + i[7:0], msk_v[i]);
        // Clear the all-ones input setting before its filter can start a pulse
        wr(8'h36, 8'h00);
        // Overvoltage: strict compare, fixed latency, hysteresis
        wr(8'h30, 8'h80);
        wr(8'h31, 8'h05);
        wr(8'h32, 8'h40);
        wr(8'h33, 8'h04);
        wr(8'h34, 8'h00);
        wr(8'h35, 8'h00);
        rail.set_level(8'h80);
        repeat (4) step();
        `CHK(flags.over_flag, 1'b0, "ov at threshold")
        rail.set_level(8'h81);
        wait_flag(2, 1'b1, 5);
        `CHK(n, 3, "ov latency")
        rail.set_level(8'h7c);
        repeat (4) step();
        `CHK(flags.sfd_fault, 1'b1, "ov hyst hold")
        rail.set_level(8'h7b);
        repeat (4) step();
        `CHK(flags.sfd_fault, 1'b0, "ov hyst release")
        // Undervoltage with raised release point
        wr(8'h34, 8'h02);
        rail.set_level(8'h3f);
        repeat (4) step();
        `CHK(flags.sfd_fault, 1'b1, "uv trip")
        `CHK(flags.under_flag, 1'b1, "uv flag")
        rail.set_level(8'h43);
        repeat (4) step();
        `CHK(flags.sfd_fault, 1'b1, "uv hyst hold")
        rail.set_level(8'h44);
        repeat (4) step();
        `CHK(flags.sfd_fault, 1'b0, "uv hyst release")
        // Every fault type against both directions
        for (int t = 0; t < 4; t++) begin
            wr(8'h34, t[7:0]);
            rail.set_level(8'h90);
            repeat (4) step();
            `CHK(flags.sfd_fault, t < 2, "type over")
            rail.set_level(8'h20);
            repeat (4) step();
            `CHK(flags.sfd_fault, t == 1 || t == 2, "type under")
            rail.set_level(8'h60);
            repeat (4) step();
        end
        // Every function select, rail over and pin high
        wr(8'h34, 8'h01);
        wr(8'h36, 8'h00);
        rail.set_pin(1'b1);
        rail.set_level(8'h90);
        for (int s = 0; s < 4; s++) begin
            wr(8'h35, s[7:0]);
            repeat (4) step();
            `CHK(flags.sfd_fault, s == 0, "sel fault")
            `CHK(flags.sfd_warning, s == 2, "sel warning")
            `CHK(flags.gpi_fault, s == 1 || s == 2, "sel input")
        end
        `CHK({flags.sfd_fault, flags.sfd_warning, flags.gpi_fault}, 3'h0, "sel off")
        // Level mode with and without inversion
        wr(8'h35, 8'h01);
        rail.set_level(8'h60);
        for (int k = 0; k < 4; k++) begin
            wr(8'h36, {1'b0, k[1], 6'h00});
            rail.set_pin(k[0]);
            repeat (3) step();
            `CHK(flags.gpi_fault, k[0] ^ k[1], "invert")
        end
        // Edge mode: no level leak, each length, alternate edges
        wr(8'h36, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h36, {3'b001, c[1:0], 3'b000});
            repeat (4) step();
            `CHK(flags.gpi_fault, 1'b0, "edge idle")
            rail.set_pin(~pin);
            wait_flag(0, 1'b1, 4);
            wait_flag(0, 1'b0, (plen[c] + 2) * TC);
            `CHK(n >= (plen[c] - 1) * TC && n <= (plen[c] + 1) * TC + 2, 1'b1, "pulse")
        end
        // Input filter: short glitch dropped, hold time per code
        wr(8'h36, 8'h01);
        rail.set_pin(1'b0);
        repeat (12) step();
        rail.pulse_pin(3 * TC);
        repeat (3) step();
        `CHK(flags.gpi_fault, 1'b0, "glitch dropped")
        for (int c = 1; c < 8; c++) begin
            wr(8'h36, c[7:0]);
            rail.set_pin(1'b1);
            wait_flag(0, 1'b1, gf[c] * TC + 4);
            `CHK(n >= (gf[c] - 1) * TC && n <= gf[c] * TC + 4, 1'b1, "in filter")
            rail.set_pin(1'b0);
            wait_flag(0, 1'b0, gf[c] * TC + 4);
        end
        // Detector glitch delay per code
        wr(8'h35, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'h34, {3'b000, c[2:0], 2'b00});
            rail.set_level(8'h90);
            wait_flag(2, 1'b1, gf[c] * TC + 4);
            `CHK(n >= (gf[c] - 1) * TC && n <= gf[c] * TC + 4, 1'b1, "sfd filter")
            rail.set_level(8'h60);
            wait_flag(2, 1'b0, gf[c] * TC + 4);
        end
        report_and_stop();
    end
endmodule : tb_dual_function_input_config
`default_nettype wire
